// File: dtp_defines.vh
// Constants for the synthesizer tuning, phase and output driver registers
`ifndef DTP_DEFINES_VH
`define DTP_DEFINES_VH

// Register indices; byte address on the bus is four times the index
`define DTP_IDX_TUNE0 12'h1A6
`define DTP_IDX_TUNE1 12'h1A7
`define DTP_IDX_TUNE2 12'h1A8
`define DTP_IDX_TUNE3 12'h1A9
`define DTP_IDX_TUNE4 12'h1AA
`define DTP_IDX_TUNE5 12'h1AB
`define DTP_IDX_PHASE_LO 12'h1AC
`define DTP_IDX_PHASE_HI 12'h1AD
`define DTP_IDX_HS_DRV 12'h200

// Bus geometry
`define DTP_ADDR_W 14
`define DTP_IDX_W 12
`define DTP_BYTE_W 8

// Tuning word and phase widths
`define DTP_TUNE_W 48
`define DTP_PHASE_W 14
`define DTP_PHASE_HI_W 6
`define DTP_START_W 4

// Default tuning word step per start-up pin code
`define DTP_TUNE_STEP 48'h0100_0000_0000

// Output driver control fields
`define DTP_HS_POL_BIT 4
`define DTP_HS_DBL_HI 1
`define DTP_HS_DBL_LO 0
`define DTP_HS_DBL_OFF 2'h1
`define DTP_HS_DBL_ON 2'h2
`define DTP_HS_DRV_RST 8'h01
`define DTP_HS_DRV_MASK 8'h13

// Start-up load sequence states
`define DTP_ST_WAIT 2'h0
`define DTP_ST_LOAD 2'h1
`define DTP_ST_RUN 2'h2
`define DTP_ST_SETTLE 2'h3

`endif

// File: dtp_regs.v
// Synthesizer tuning word, phase offset and output driver register bank
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defines.vh"

// Function
// RULE_01: Six byte registers form a 48-bit tuning word, lowest address least significant.
// RULE_02: The tuning word sets output frequency as a fixed ratio of system clock.
// RULE_03: After reset the tuning word loads a default picked by four start-up pins.
// RULE_04: A new tuning word changes frequency at once without any phase jump.
// RULE_05: Phase offset is 14 bits: low register bits 7..0, next register bits 13..8.
// RULE_06: The phase offset adds to synthesized phase; brief glitches at 45 degrees allowed.
// RULE_07: Driver control bit 4 set inverts the high-speed output polarity.
// RULE_08: Doubler field 01 turns the output doubler off, 10 turns it on.
// RULE_09: Software enabling the doubler also sets bit 5 of register 0x0010.
// RULE_10: A 48-bit accumulator adds the tuning word every cycle, wrapping naturally.
module dtp_regs (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`DTP_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Start-up configuration pins, asynchronous
  input wire [`DTP_START_W-1:0] startup_select_pin,
  // Synthesizer outputs
  output reg [`DTP_PHASE_W-1:0] dds_phase,
  output reg hs_out,
  output reg hs_doubler_on,
  output reg output_polarity_invert,
  output reg startup_done
);

  // Register storage
  reg [`DTP_TUNE_W-1:0] frequency_tuning_word;
  reg [`DTP_BYTE_W-1:0] phase_offset_low;
  reg [`DTP_PHASE_HI_W-1:0] phase_offset_high;
  reg [`DTP_BYTE_W-1:0] hs_output_driver_ctrl;

  // Synthesis state
  reg [`DTP_TUNE_W-1:0] phase_acc;
  reg [`DTP_TUNE_W-1:0] next_phase_acc;
  reg [`DTP_PHASE_W-1:0] next_dds_phase;
  reg [1:0] load_state;
  reg [1:0] next_load_state;

  // Synchronised start-up pins
  wire [`DTP_START_W-1:0] startup_sync;

  // Bus decode
  wire [`DTP_IDX_W-1:0] reg_idx;
  wire addr_aligned;
  wire setup_phase;
  wire wr_commit;
  wire [`DTP_BYTE_W-1:0] wbyte;
  reg idx_valid;
  reg [`DTP_BYTE_W-1:0] rd_byte;

  // Assembled phase offset word
  wire [`DTP_PHASE_W-1:0] phase_offset_word;

  // Pins cross into the clock domain before use
  dtp_sync2 #(
    .WIDTH(`DTP_START_W)
  ) u_start_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(startup_select_pin),
    .sync_out(startup_sync)
  );

  // Index is the word address; the low two bits must be zero
  assign reg_idx = paddr[`DTP_ADDR_W-1:2];
  assign addr_aligned = (paddr[1:0] == 2'h0);
  assign setup_phase = psel & ~penable & ~pready;
  assign wr_commit = psel & penable & pready & pwrite & ~pslverr;
  assign wbyte = pwdata[`DTP_BYTE_W-1:0];

  // High byte holds bits 13..8 in its low six bits
  assign phase_offset_word = {phase_offset_high, phase_offset_low}; // [RULE_05]

  // Read mux and map check; reserved bits read as zero
  always @* begin
    idx_valid = 1'b1;
    rd_byte = {`DTP_BYTE_W{1'b0}};
    case (reg_idx)
      `DTP_IDX_TUNE0: rd_byte = frequency_tuning_word[7:0]; // [RULE_01]
      `DTP_IDX_TUNE1: rd_byte = frequency_tuning_word[15:8];
      `DTP_IDX_TUNE2: rd_byte = frequency_tuning_word[23:16];
      `DTP_IDX_TUNE3: rd_byte = frequency_tuning_word[31:24];
      `DTP_IDX_TUNE4: rd_byte = frequency_tuning_word[39:32];
      `DTP_IDX_TUNE5: rd_byte = frequency_tuning_word[47:40];
      `DTP_IDX_PHASE_LO: rd_byte = phase_offset_low;
      `DTP_IDX_PHASE_HI: rd_byte = {2'h0, phase_offset_high};
      `DTP_IDX_HS_DRV: rd_byte = hs_output_driver_ctrl & `DTP_HS_DRV_MASK;
      default: idx_valid = 1'b0;
    endcase
  end

  // APB answer: one flop-driven ready pulse after each setup cycle,
  // so every transfer completes with no wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      pready <= 1'b1;
      pslverr <= ~(idx_valid & addr_aligned);
      if (!pwrite && idx_valid && addr_aligned) begin
        prdata <= {24'h00_0000, rd_byte};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Start-up sequence: two waits so the synchroniser holds the pin code,
  // since its flops clear in reset and would otherwise load zero
  always @* begin
    next_load_state = load_state;
    case (load_state)
      `DTP_ST_WAIT: next_load_state = `DTP_ST_SETTLE;
      `DTP_ST_SETTLE: next_load_state = `DTP_ST_LOAD;
      `DTP_ST_LOAD: next_load_state = `DTP_ST_RUN;
      `DTP_ST_RUN: next_load_state = `DTP_ST_RUN;
      default: next_load_state = `DTP_ST_WAIT;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_state <= `DTP_ST_WAIT;
      startup_done <= 1'b0;
    end else begin
      load_state <= next_load_state;
      startup_done <= (next_load_state == `DTP_ST_RUN);
    end
  end

  // Tuning word bytes; pin default lands after the synchroniser settles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frequency_tuning_word <= {`DTP_TUNE_W{1'b0}};
    end else if (load_state == `DTP_ST_LOAD) begin
      // Default is the pin code times a fixed step [RULE_03]
      frequency_tuning_word <= `DTP_TUNE_STEP *
        {{(`DTP_TUNE_W-`DTP_START_W){1'b0}}, startup_sync};
    end else if (wr_commit) begin
      // Each byte lands in its own lane of the word [RULE_01]
      case (reg_idx)
        `DTP_IDX_TUNE0: frequency_tuning_word[7:0] <= wbyte;
        `DTP_IDX_TUNE1: frequency_tuning_word[15:8] <= wbyte;
        `DTP_IDX_TUNE2: frequency_tuning_word[23:16] <= wbyte;
        `DTP_IDX_TUNE3: frequency_tuning_word[31:24] <= wbyte;
        `DTP_IDX_TUNE4: frequency_tuning_word[39:32] <= wbyte;
        `DTP_IDX_TUNE5: frequency_tuning_word[47:40] <= wbyte;
        default: frequency_tuning_word <= frequency_tuning_word;
      endcase
    end
  end

  // Phase offset and driver control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_offset_low <= {`DTP_BYTE_W{1'b0}};
      phase_offset_high <= {`DTP_PHASE_HI_W{1'b0}};
      hs_output_driver_ctrl <= `DTP_HS_DRV_RST;
    end else if (wr_commit) begin
      case (reg_idx)
        `DTP_IDX_PHASE_LO: phase_offset_low <= wbyte; // [RULE_05]
        `DTP_IDX_PHASE_HI:
          phase_offset_high <= wbyte[`DTP_PHASE_HI_W-1:0]; // [RULE_05]
        `DTP_IDX_HS_DRV:
          hs_output_driver_ctrl <= wbyte & `DTP_HS_DRV_MASK;
        default: phase_offset_low <= phase_offset_low;
      endcase
    end
  end

  // Accumulator keeps its value across tuning changes, so only the slope
  // changes and the phase never steps [RULE_04]
  always @* begin
    next_phase_acc = phase_acc + frequency_tuning_word; // [RULE_10] [RULE_02]
  end

  // Offset adds to the top bits; a torn two-byte write may glitch briefly,
  // which is acceptable since the partial offset lasts only until the second byte lands
  always @* begin
    next_dds_phase = phase_acc[`DTP_TUNE_W-1:`DTP_TUNE_W-`DTP_PHASE_W] +
      phase_offset_word; // [RULE_06]
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_acc <= {`DTP_TUNE_W{1'b0}};
      dds_phase <= {`DTP_PHASE_W{1'b0}};
    end else begin
      // Sum wraps modulo two to the 48th by width [RULE_10]
      phase_acc <= next_phase_acc;
      dds_phase <= next_dds_phase;
    end
  end

  // Doubler state: 01 off, 10 on, other codes keep the last decode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_doubler_on <= 1'b0;
    end else begin
      case (hs_output_driver_ctrl[`DTP_HS_DBL_HI:`DTP_HS_DBL_LO])
        `DTP_HS_DBL_OFF: hs_doubler_on <= 1'b0; // [RULE_08]
        `DTP_HS_DBL_ON: hs_doubler_on <= 1'b1; // [RULE_08]
        default: hs_doubler_on <= hs_doubler_on;
      endcase
    end
  end

  // Square output from phase msb; doubled rate uses the next bit down.
  // Software must also set the pll-side enable bit elsewhere [RULE_09]
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_out <= 1'b0;
      output_polarity_invert <= 1'b0;
    end else begin
      output_polarity_invert <=
        hs_output_driver_ctrl[`DTP_HS_POL_BIT]; // [RULE_07]
      hs_out <= (hs_doubler_on ? dds_phase[`DTP_PHASE_W-2] :
        dds_phase[`DTP_PHASE_W-1]) ^
        hs_output_driver_ctrl[`DTP_HS_POL_BIT]; // [RULE_07]
    end
  end

endmodule // dtp_regs

`default_nettype wire

// File: dtp_regs_monitor.sv
// Assertion checker for the tuning, phase and driver register bank
`timescale 1ns/1ps
`default_nettype none
module dtp_regs_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Synthesizer outputs
  input wire logic [13:0] dds_phase,
  input wire logic hs_out,
  input wire logic hs_doubler_on,
  input wire logic output_polarity_invert,
  input wire logic startup_done
);
  // Completed write to the driver control word
  wire wd = psel && penable && pwrite && pready && paddr == 14'h0800;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  misalign_err_a: assert property (psel && !penable && paddr[1:0] != 2'h0
    |=> pslverr) else $error("misaligned not refused");
  rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  pol_copy_a: assert property (wd |-> ##2
    output_polarity_invert == $past(pwdata[4], 2)) else $error("polarity");
  dbl_on_a: assert property (wd && pwdata[1:0] == 2'h2
    |-> ##2 hs_doubler_on) else $error("doubler not on");
  dbl_off_a: assert property (wd && pwdata[1:0] == 2'h1
    |-> ##2 !hs_doubler_on) else $error("doubler not off");
  start_load_a: assert property ($rose(presetn)
    |-> !startup_done ##[1:3] startup_done) else $error("no default load");
  hs_square_a: assert property ((($stable(output_polarity_invert) &&
    $stable(hs_doubler_on)))[*2] |-> hs_out == (output_polarity_invert ^
    (hs_doubler_on ? $past(dds_phase[12]) : $past(dds_phase[13]))))
    else $error("output square wrong");
  // Main scenarios
  wr_c: cover property (wd);
  err_c: cover property (pslverr);
  dbl_c: cover property (hs_doubler_on && hs_out);
endmodule // dtp_regs_monitor

bind dtp_regs dtp_regs_monitor u_dtp_regs_monitor (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dds_phase,
  .hs_out, .hs_doubler_on, .output_polarity_invert, .startup_done);
`default_nettype wire

// File: dtp_regs_tb.sv
// Self-checking bench for the tuning, phase and driver register bank
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defines.vh"
module dtp_regs_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic hs_out, hs_doubler_on, output_polarity_invert, startup_done;
  logic [13:0] paddr, dds_phase, d0;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] startup_select_pin;
  int failures, n_tests;

  dtp_regs u_dtp_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .startup_select_pin, .dds_phase,
    .hs_out, .hs_doubler_on, .output_polarity_invert, .startup_done);

  // Clock at 4 ns
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask

  // One APB transfer; request held until ready is sampled high
  task automatic apb(logic w, logic [11:0] i, logic [7:0] d,
      logic [1:0] lo = 2'h0);
    int n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {i, lo};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) begin
      failures++;
      tally_and_finish;
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Phase advance per cycle, measured once the pipeline has settled
  task automatic step(string nm, logic [13:0] x);
    logic [13:0] a;
    repeat (4) @(posedge pclk);
    a = dds_phase;
    @(posedge pclk);
    chk(nm, 14'(dds_phase - a), x);
  endtask

  task automatic load_tune(logic [47:0] v);
    for (int k = 0; k < 6; k++) apb(1, 12'(`DTP_IDX_TUNE0 + k), v[8*k+:8]);
  endtask

  task tally_and_finish;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #40000;
    failures++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    startup_select_pin = 4'h3;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (6) @(posedge pclk);
    chk("startup_done", startup_done, 32'h1);
    for (int k = 0; k < 6; k++) begin
      apb(0, 12'(`DTP_IDX_TUNE0 + k), 8'h0);
      chk("ftw byte", r, k == 5 ? 32'h3 : 32'h0);
    end
    apb(0, `DTP_IDX_HS_DRV, 8'h0);
    chk("drv reset", r, 32'h1);
    step("default step", 14'h00C0);
    $display("test defaults done");
    apb(1, `DTP_IDX_PHASE_HI, 8'hFF);
    apb(0, `DTP_IDX_PHASE_HI, 8'h0);
    chk("phase hi", r, 32'h3F);
    apb(1, `DTP_IDX_HS_DRV, 8'hFF);
    apb(0, `DTP_IDX_HS_DRV, 8'h0);
    chk("drv mask", r, 32'h13);
    load_tune(48'h0004_0000_0000);
    step("bit34 step", 14'h0001);
    load_tune(48'h0100_0000_0000);
    step("byte5 step", 14'h0040);
    $display("test tuning done");
    load_tune(48'h0);
    apb(1, `DTP_IDX_PHASE_LO, 8'h0);
    apb(1, `DTP_IDX_PHASE_HI, 8'h0);
    step("stopped", 14'h0);
    d0 = dds_phase;
    apb(1, `DTP_IDX_PHASE_LO, 8'h34);
    apb(1, `DTP_IDX_PHASE_HI, 8'h12);
    repeat (4) @(posedge pclk);
    chk("phase offset", 14'(dds_phase - d0), 14'h1234);
    $display("test phase done");
    load_tune(48'h1000_0000_0000);
    apb(1, `DTP_IDX_HS_DRV, 8'h12);
    repeat (3) @(posedge pclk);
    chk("pol on", output_polarity_invert, 32'h1);
    chk("dbl on", hs_doubler_on, 32'h1);
    apb(1, `DTP_IDX_HS_DRV, 8'h01);
    repeat (3) @(posedge pclk);
    chk("dbl off", hs_doubler_on, 32'h0);
    $display("test driver done");
    apb(1, 12'h010, 8'h20);
    chk("outside reg", e, 32'h1);
    apb(0, 12'h1A5, 8'h0);
    chk("unmapped data", r, 32'h0);
    apb(1, `DTP_IDX_HS_DRV, 8'h10, 2'h2);
    chk("misaligned", e, 32'h1);
    apb(0, `DTP_IDX_HS_DRV, 8'h0);
    chk("drv kept", r, 32'h1);
    $display("test errors done");
    tally_and_finish;
  end
endmodule // dtp_regs_tb
`default_nettype wire

// File: dtp_sync2.v
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none

module dtp_sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Level in and out
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // First stage is read only by the second stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // dtp_sync2

`default_nettype wire
